// ===== design/mlst_cfg.svh
`ifndef MLST_CFG_SVH
`define MLST_CFG_SVH

// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
`define MLST_IDX_SCRATCH 16'ha014
`define MLST_IDX_CMD 16'ha016
`define MLST_IDX_INT_STAT 16'ha018
`define MLST_IDX_INT_MASK 16'ha019
`define MLST_AXI_AW 18

// ==========================================================================
// Field positions and reset values.
`define MLST_MODE_LSB 4
`define MLST_MODE_MON_BIT 3
`define MLST_ACTIVE_BIT 3
`define MLST_FAIL_BIT 1
`define MLST_FINISH_BIT 0
`define MLST_SCRATCH_RST 8'h00
`define MLST_MODE_RST 4'h0
`define MLST_INT_RST 2'h0

// ==========================================================================
// Command codes, test selections and bus answers.
`define MLST_CMD_RUN 4'h5
`define MLST_CMD_RUN_RST 4'ha
`define MLST_CMD_CLEAR 4'h0
`define MLST_SEL_MEM 3'h1
`define MLST_SEL_LOGIC 3'h4
`define MLST_RESP_OKAY 2'h0
`define MLST_RESP_SLVERR 2'h2

// ==========================================================================
// Logic self-test length in clock cycles.
`define MLST_LGC_CYCLES 1024

`endif

// ===== design/mlst_pkg.sv
`include "mlst_cfg.svh"

package mlst_pkg;

  // ========================================================================
  // Controller states.
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01,
    ST_LOGIC = 2'b10
  } mlst_state_e;

  // ========================================================================
  // Progress shown on the monitor pins.
  typedef struct packed
  {
    logic active;
    logic fail;
    logic [3:0] progress;
  } mlst_mon_s;

  // Status fields of the command register.
  typedef struct packed
  {
    logic active;
    logic fail;
    logic finish;
  } mlst_status_s;

endpackage

// ===== design/mlst_mem_march.sv
`timescale 1ns/1ns

module mlst_mem_march #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic clk_sys_i,            // System clock.
  input wire logic resetn_i,             // Power-on reset, active low.
  input wire logic start_i,              // Start pulse.
  input wire logic abort_i,              // Abort pulse.
  output logic busy_o,                   // Test running.
  output logic done_o,                   // Completion pulse.
  output logic err_o,                    // Miscompare seen.
  output logic [3:0] progress_o,         // Phase and address top bits.
  output logic [AW-1:0] mem_addr_o,      // SRAM address.
  output logic mem_we_o,                 // SRAM write enable.
  output logic [DW-1:0] mem_wdata_o,     // SRAM write data.
  input wire logic [DW-1:0] mem_rdata_i  // SRAM read data, same cycle.
);

  // ========================================================================
  // Four passes: write pattern, check it, write inverse, check it.
  logic busy_q;
  logic done_q;
  logic err_q;
  logic [1:0] phase_q;
  logic [AW-1:0] addr_q;
  wire [DW-1:0] pat = {(DW/2){2'b01}};
  wire [DW-1:0] expect_w = phase_q[1] ? ~pat : pat;
  wire last_w = &addr_q;
  wire miss_w = busy_q & phase_q[0] & (mem_rdata_i != expect_w);

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign err_o = err_q;
  assign progress_o = {phase_q, addr_q[AW-1 -: 2]};
  assign mem_addr_o = addr_q;
  assign mem_we_o = busy_q & ~phase_q[0];
  assign mem_wdata_o = expect_w;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      phase_q <= 2'h0;
      addr_q <= '0;
    end
    else
    begin
      done_q <= busy_q & ~abort_i & last_w & (&phase_q);
      if (abort_i)
        busy_q <= 1'b0;
      else if (start_i)
      begin
        busy_q <= 1'b1;
        err_q <= 1'b0;
        phase_q <= 2'h0;
        addr_q <= '0;
      end
      else if (busy_q)
      begin
        addr_q <= addr_q + 1'b1;
        err_q <= err_q | miss_w;
        if (last_w)
        begin
          phase_q <= phase_q + 2'h1;
          busy_q <= ~(&phase_q);
        end
      end
    end
  end

endmodule

// ===== design/mlst_logic_sig.sv
`timescale 1ns/1ns
`include "mlst_cfg.svh"

module mlst_logic_sig #(
  parameter int W = 16,
  parameter int CYCLES = `MLST_LGC_CYCLES,
  parameter logic [W-1:0] TAPS = 16'hb400,
  parameter logic [W-1:0] GOLDEN = 16'h0000
) (
  input wire logic clk_sys_i,       // System clock.
  input wire logic resetn_i,        // Power-on reset, active low.
  input wire logic start_i,         // Start pulse.
  input wire logic abort_i,         // Abort pulse.
  output logic busy_o,              // Test running.
  output logic done_o,              // Completion pulse.
  output logic err_o,               // Signature mismatch.
  output logic [3:0] progress_o,    // Count top bits.
  output logic [W-1:0] stim_o,      // Pattern into the logic under test.
  input wire logic [W-1:0] resp_i   // Response of the logic under test.
);

  // ========================================================================
  // Pseudo-random patterns out, responses compacted into a signature.
  localparam int CW = $clog2(CYCLES) + 1;
  logic busy_q;
  logic done_q;
  logic err_q;
  logic [CW-1:0] cnt_q;
  logic [W-1:0] lfsr_q;
  logic [W-1:0] misr_q;
  wire [W-1:0] next_lfsr = {lfsr_q[W-2:0], ^(lfsr_q & TAPS)};
  wire [W-1:0] next_misr = {misr_q[W-2:0], ^(misr_q & TAPS)} ^ resp_i;
  wire last_w = cnt_q == CW'(CYCLES - 1);

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign err_o = err_q;
  assign progress_o = cnt_q[CW-1 -: 4];
  assign stim_o = lfsr_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      cnt_q <= '0;
      lfsr_q <= {{(W-1){1'b0}}, 1'b1};
      misr_q <= '0;
    end
    else
    begin
      done_q <= busy_q & ~abort_i & last_w;
      if (abort_i)
        busy_q <= 1'b0;
      else if (start_i)
      begin
        busy_q <= 1'b1;
        err_q <= 1'b0;
        cnt_q <= '0;
        lfsr_q <= {{(W-1){1'b0}}, 1'b1};
        misr_q <= '0;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q + 1'b1;
        lfsr_q <= next_lfsr;
        misr_q <= next_misr;
        if (last_w)
        begin
          busy_q <= 1'b0;
          err_q <= next_misr != GOLDEN;
        end
      end
    end
  end

endmodule

// ===== design/mlst_ctrl.sv
`timescale 1ns/1ns
`include "mlst_cfg.svh"

module mlst_ctrl #(
  parameter int MEM_AW = 11,
  parameter int MEM_DW = 8,
  parameter int LGC_W = 16,
  parameter int LGC_CYCLES = `MLST_LGC_CYCLES,
  // Expected logic signature; the value is arbitrary and set per chip.
  parameter logic [LGC_W-1:0] LGC_GOLDEN = 16'h0000
) (
  input wire logic clk_sys_i,                       // System clock.
  input wire logic resetn_i,                        // Power-on reset, active low.
  input wire logic external_reset_pin_n_i,          // Reset pin, active low.
  input wire logic soft_reset_i,                    // Software reset pulse.
  input wire logic [`MLST_AXI_AW-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid,                   // Write address valid.
  output logic s_axi_awready,                       // Write address ready.
  input wire logic [31:0] s_axi_wdata,              // Write data.
  input wire logic [3:0] s_axi_wstrb,               // Write strobes.
  input wire logic s_axi_wvalid,                    // Write data valid.
  output logic s_axi_wready,                        // Write data ready.
  output logic [1:0] s_axi_bresp,                   // Write response.
  output logic s_axi_bvalid,                        // Write response valid.
  input wire logic s_axi_bready,                    // Write response ready.
  input wire logic [`MLST_AXI_AW-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid,                   // Read address valid.
  output logic s_axi_arready,                       // Read address ready.
  output logic [31:0] s_axi_rdata,                  // Read data.
  output logic [1:0] s_axi_rresp,                   // Read response.
  output logic s_axi_rvalid,                        // Read valid.
  input wire logic s_axi_rready,                    // Read ready.
  output logic irq_o,                               // Interrupt, level.
  output logic cpu_pause_o,                         // Holds the CPU.
  output logic soft_reset_req_o,                    // Software reset request.
  output mlst_pkg::mlst_mon_s mon_o,                // Progress monitor pins.
  output logic [MEM_AW-1:0] mem_addr_o,             // SRAM address.
  output logic mem_we_o,                            // SRAM write enable.
  output logic [MEM_DW-1:0] mem_wdata_o,            // SRAM write data.
  input wire logic [MEM_DW-1:0] mem_rdata_i,        // SRAM read data.
  output logic [LGC_W-1:0] lgc_stim_o,              // Logic test pattern.
  input wire logic [LGC_W-1:0] lgc_resp_i           // Logic test response.
);

  // ==========================================================================
  // Write and read channel holding registers.
  logic aw_hold_q;
  logic [`MLST_AXI_AW-1:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ==========================================================================
  // Address decode.
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire rd_fire = s_axi_arvalid & ~rvalid_q;
  wire [15:0] wr_idx = aw_addr_q[`MLST_AXI_AW-1:2];
  wire [15:0] rd_idx = s_axi_araddr[`MLST_AXI_AW-1:2];
  wire wr_scr = wr_idx == `MLST_IDX_SCRATCH;
  wire wr_cmdr = wr_idx == `MLST_IDX_CMD;
  wire wr_ist = wr_idx == `MLST_IDX_INT_STAT;
  wire wr_imk = wr_idx == `MLST_IDX_INT_MASK;
  wire wr_hit = wr_scr | wr_cmdr | wr_ist | wr_imk;
  wire rd_scr = rd_idx == `MLST_IDX_SCRATCH;
  wire rd_cmdr = rd_idx == `MLST_IDX_CMD;
  wire rd_ist = rd_idx == `MLST_IDX_INT_STAT;
  wire rd_imk = rd_idx == `MLST_IDX_INT_MASK;
  wire rd_hit = rd_scr | rd_cmdr | rd_ist | rd_imk;
  wire wr_lo = wr_fire & w_strb_q[0];

  // ==========================================================================
  // Command decode.
  mlst_pkg::mlst_state_e state_q;
  logic [3:0] mode_q;
  logic [3:0] run_mode_q;
  logic auto_rst_q;
  logic finish_q;
  logic fail_q;
  logic [7:0] scratch_q;
  logic [1:0] int_stat_q;
  logic [1:0] int_mask_q;
  logic soft_req_q;
  mlst_pkg::mlst_mon_s mon_q;

  wire [3:0] wr_cmd_val = w_data_q[3:0];
  wire [3:0] wr_mode_val = w_data_q[`MLST_MODE_LSB +: 4];
  wire cmd_wr = wr_lo & wr_cmdr;
  wire is_run = wr_cmd_val == `MLST_CMD_RUN;
  wire is_run_rst = wr_cmd_val == `MLST_CMD_RUN_RST;
  wire is_clear = wr_cmd_val == `MLST_CMD_CLEAR;
  wire sel_mem = wr_mode_val[2:0] == `MLST_SEL_MEM;
  wire sel_lgc = wr_mode_val[2:0] == `MLST_SEL_LOGIC;
  wire idle_w = state_q == mlst_pkg::ST_IDLE;
  wire cmd_start = cmd_wr & (is_run | is_run_rst) & idle_w & (sel_mem | sel_lgc);
  wire cmd_clear = cmd_wr & is_clear;
  wire cmd_abort = cmd_wr & ~is_run & ~is_run_rst & ~is_clear;
  wire pin_rst = ~external_reset_pin_n_i;
  wire abort_w = cmd_abort | soft_reset_i | pin_rst;

  // ==========================================================================
  // Test engines.
  logic mem_busy;
  logic mem_done;
  logic mem_err;
  logic [3:0] mem_prog;
  logic lgc_busy;
  logic lgc_done;
  logic lgc_err;
  logic [3:0] lgc_prog;

  mlst_mem_march #(
    .AW(MEM_AW),
    .DW(MEM_DW)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .start_i(cmd_start & sel_mem),
    .abort_i(abort_w),
    .busy_o(mem_busy),
    .done_o(mem_done),
    .err_o(mem_err),
    .progress_o(mem_prog),
    .mem_addr_o(mem_addr_o),
    .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i)
  );

  mlst_logic_sig #(
    .W(LGC_W),
    .CYCLES(LGC_CYCLES),
    .GOLDEN(LGC_GOLDEN)
  ) u_lgc (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .start_i(cmd_start & sel_lgc),
    .abort_i(abort_w),
    .busy_o(lgc_busy),
    .done_o(lgc_done),
    .err_o(lgc_err),
    .progress_o(lgc_prog),
    .stim_o(lgc_stim_o),
    .resp_i(lgc_resp_i)
  );

  wire done_w = mem_done | lgc_done;
  wire err_w = (mem_done & mem_err) | (lgc_done & lgc_err);
  wire active_w = ~idle_w;
  wire live_err = (state_q == mlst_pkg::ST_MEM) ? mem_err : lgc_err;

  // ==========================================================================
  // Controller state; the engine's done pulse returns it to idle.
  mlst_pkg::mlst_state_e next_state;

  always_comb
  begin
    next_state = state_q;
    case (state_q)
      mlst_pkg::ST_IDLE:
        if (cmd_start)
          next_state = sel_mem ? mlst_pkg::ST_MEM : mlst_pkg::ST_LOGIC;
      mlst_pkg::ST_MEM:
        if (abort_w | mem_done | ~mem_busy)
          next_state = mlst_pkg::ST_IDLE;
      mlst_pkg::ST_LOGIC:
        if (abort_w | lgc_done | ~lgc_busy)
          next_state = mlst_pkg::ST_IDLE;
      default:
        next_state = mlst_pkg::ST_IDLE;
    endcase
  end

  // The started flag lets the engine register its start before its busy is checked.
  logic started_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= mlst_pkg::ST_IDLE;
      started_q <= 1'b0;
    end
    else
    begin
      started_q <= cmd_start;
      state_q <= (started_q & ~abort_w) ? state_q : next_state;
    end
  end

  assign cpu_pause_o = active_w;

  // ==========================================================================
  // Mode and run options, kept through software resets.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mode_q <= `MLST_MODE_RST;
    else if (pin_rst)
      mode_q <= `MLST_MODE_RST;
    else if (cmd_wr)
      mode_q <= wr_mode_val;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_mode_q <= `MLST_MODE_RST;
      auto_rst_q <= 1'b0;
    end
    else if (cmd_start)
    begin
      run_mode_q <= wr_mode_val;
      auto_rst_q <= is_run_rst;
    end
  end

  // ==========================================================================
  // Finished and failed flags; a completion wins over a clear.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      finish_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else if (pin_rst)
    begin
      finish_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      finish_q <= done_w | (finish_q & ~cmd_clear & ~cmd_start);
      fail_q <= err_w | (fail_q & ~cmd_clear & ~cmd_start);
    end
  end

  // ==========================================================================
  // Automatic software reset after a test that asked for it.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      soft_req_q <= 1'b0;
    else
      soft_req_q <= done_w & auto_rst_q;
  end

  assign soft_reset_req_o = soft_req_q;

  // ==========================================================================
  // Scratch register, cleared only at power-on.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      scratch_q <= `MLST_SCRATCH_RST;
    else if (wr_lo & wr_scr)
      scratch_q <= w_data_q[7:0];
  end

  // ==========================================================================
  // Interrupt status, write one to clear; a new event wins.
  wire [1:0] int_set = {err_w, done_w};
  wire [1:0] int_clr = (wr_lo & wr_ist) ? w_data_q[1:0] : 2'h0;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      int_stat_q <= `MLST_INT_RST;
      int_mask_q <= `MLST_INT_RST;
    end
    else if (pin_rst)
    begin
      int_stat_q <= `MLST_INT_RST;
      int_mask_q <= `MLST_INT_RST;
    end
    else
    begin
      int_stat_q <= int_set | (int_stat_q & ~int_clr);
      if (wr_lo & wr_imk)
        int_mask_q <= w_data_q[1:0];
    end
  end

  assign irq_o = |(int_stat_q & int_mask_q);

  // ==========================================================================
  // Progress pins, driven only in a monitored run.
  wire mon_en = active_w & run_mode_q[`MLST_MODE_MON_BIT];
  wire [3:0] prog_w = (state_q == mlst_pkg::ST_MEM) ? mem_prog : lgc_prog;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mon_q <= '0;
    else if (mon_en)
      mon_q <= '{active: 1'b1, fail: live_err, progress: prog_w};
    else
      mon_q <= '0;
  end

  assign mon_o = mon_q;

  // ==========================================================================
  // Read data.
  mlst_pkg::mlst_status_s stat_w;
  assign stat_w = '{active: active_w, fail: fail_q, finish: finish_q};

  wire [7:0] cmd_rd = {mode_q, stat_w.active, 1'b0, stat_w.fail, stat_w.finish};
  wire [31:0] rd_mux = rd_scr ? {24'h00_0000, scratch_q} :
                       rd_cmdr ? {24'h00_0000, cmd_rd} :
                       rd_ist ? {30'h0000_0000, int_stat_q} :
                       rd_imk ? {30'h0000_0000, int_mask_q} : 32'h0000_0000;

  // ==========================================================================
  // Bus handshakes.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `MLST_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `MLST_RESP_OKAY : `MLST_RESP_SLVERR;
      end
      else if (bvalid_q & s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `MLST_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? `MLST_RESP_OKAY : `MLST_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule

// ===== dv/mlst_ctrl_properties.sv
`timescale 1ns/1ns
module mlst_ctrl_chk (
  input wire logic clk_sys_i, // Clock.
  input wire logic resetn_i, // Reset.
  input wire logic s_axi_awvalid, // AW valid.
  input wire logic s_axi_awready, // AW ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic cpu_pause_o, // CPU hold.
  input wire logic soft_reset_req_o, // Reset request.
  input wire logic mem_we_o, // SRAM write.
  input wire mlst_pkg::mlst_mon_s mon_o // Monitor pins.
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  mem_paused_a: assert property (mem_we_o |-> cpu_pause_o)
    else $error("SRAM written while CPU runs");
  mon_active_a: assert property (mon_o.active |-> cpu_pause_o || $past(cpu_pause_o))
    else $error("monitor active without test");
  reset_pulse_a: assert property (soft_reset_req_o |=> !soft_reset_req_o)
    else $error("reset request too long");
  reset_after_a: assert property (soft_reset_req_o |-> !cpu_pause_o && ($past(cpu_pause_o) || $past(cpu_pause_o, 2)))
    else $error("reset request not after test");
endmodule

bind mlst_ctrl mlst_ctrl_chk u_chk (.*);

// ===== dv/mlst_ctrl_tb.sv
`timescale 1ns/1ns
module mlst_ctrl_tb;
  localparam logic [17:0] SCR = 18'h2_8050, CMD = 18'h2_8058, IST = 18'h2_8060, IMK = 18'h2_8064;
  logic clk_sys_i = 0, resetn_i = 0, external_reset_pin_n_i = 1, soft_reset_i = 0, fault = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic irq_o, cpu_pause_o, soft_reset_req_o, mem_we_o;
  mlst_pkg::mlst_mon_s mon_o;
  logic [3:0] mem_addr_o;
  logic [7:0] mem_wdata_o, mem_rdata_i;
  logic [15:0] lgc_stim_o, lgc_resp_i;
  logic [7:0] sram [16];
  int fails = 0, n_compared = 0, cyc = 0, n_srq = 0;

  mlst_ctrl #(.MEM_AW(4), .LGC_CYCLES(16)) uut (.*);

  always #50 clk_sys_i = ~clk_sys_i;
  assign lgc_resp_i = lgc_stim_o;
  // The fault flag flips one read bit so the memory test must miscompare.
  assign mem_rdata_i = sram[mem_addr_o] ^ {7'h00, fault};

  always @(posedge clk_sys_i)
  begin
    if (mem_we_o === 1'b1)
      sram[mem_addr_o] <= mem_wdata_o;
    if (soft_reset_req_o === 1'b1)
      n_srq <= n_srq + 1;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready === 1'b1)
        pa = 1'b0;
      if (s_axi_wready === 1'b1)
        pw = 1'b0;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] m, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge clk_sys_i);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & {24'hff_ffff, m}, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask

  task automatic run(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m);
    wr(CMD, c, 2'h0);
    chk({31'h0, cpu_pause_o}, 32'h1);
    rd(CMD, 8'h0b, 32'h8, 2'h0);
    chk({31'h0, mon_o.active}, {31'h0, c[7]});
    repeat (300)
      if (cpu_pause_o === 1'b1)
        @(posedge clk_sys_i);
    chk({31'h0, cpu_pause_o}, 32'h0);
    rd(CMD, m, {24'h00_0000, e}, 2'h0);
  endtask

  task automatic t_regs;
    rd(CMD, 8'hff, 32'h0, 2'h0);
    rd(SCR, 8'hff, 32'h0, 2'h0);
    wr(SCR, 8'ha5, 2'h0);
    rd(SCR, 8'hff, 32'ha5, 2'h0);
    wr(18'h0_0000, 8'h11, 2'h2);
    rd(18'h0_0000, 8'hff, 32'h0, 2'h2);
  endtask

  task automatic t_modes;
    logic [7:0] c [4] = '{8'h15, 8'h45, 8'h95, 8'hc5};
    logic [7:0] r [3] = '{8'h25, 8'h05, 8'hf5};
    int k;
    foreach (c[i])
      run(c[i], {c[i][7:4], 4'h1}, c[i][6] ? 8'hf9 : 8'hfb);
    foreach (r[i])
    begin
      wr(CMD, r[i], 2'h0);
      chk({31'h0, cpu_pause_o}, 32'h0);
    end
    k = n_srq;
    run(8'h15, 8'h11, 8'hfb);
    chk(n_srq - k, 0);
    run(8'h1a, 8'h11, 8'hfb);
    chk(n_srq - k, 1);
  endtask

  task automatic t_fault;
    wr(IST, 8'h03, 2'h0);
    fault <= 1'b1;
    run(8'h15, 8'h13, 8'hff);
    fault <= 1'b0;
    rd(IST, 8'hff, 32'h3, 2'h0);
    wr(IMK, 8'h01, 2'h0);
    chk({31'h0, irq_o}, 32'h1);
    wr(IST, 8'h01, 2'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(IMK, 8'h02, 2'h0);
    chk({31'h0, irq_o}, 32'h1);
    wr(IST, 8'h02, 2'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(CMD, 8'h10, 2'h0);
    rd(CMD, 8'hff, 32'h10, 2'h0);
    wr(CMD, 8'h15, 2'h0);
    wr(CMD, 8'h13, 2'h0);
    chk({31'h0, cpu_pause_o}, 32'h0);
    rd(CMD, 8'hff, 32'h10, 2'h0);
  endtask

  task automatic t_resets;
    run(8'h15, 8'h11, 8'hff);
    soft_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    soft_reset_i <= 1'b0;
    rd(CMD, 8'hff, 32'h11, 2'h0);
    external_reset_pin_n_i <= 1'b0;
    @(posedge clk_sys_i);
    external_reset_pin_n_i <= 1'b1;
    rd(CMD, 8'hff, 32'h0, 2'h0);
    rd(SCR, 8'hff, 32'ha5, 2'h0);
  endtask

  task automatic complete_run;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_modes();
    t_fault();
    t_resets();
    complete_run();
  end
endmodule
